// *** conv_ctrl_pkg.sv ***
// constants and types for the converter pin, clock and result control block
// What this block does
// - lowest pin-disable register bits 0..7 govern channel pins 0..7
// - middle pin-disable register bits 0..7 govern channel pins 8..15
// - highest pin-disable register bits 0..7 govern channel pins 16..23
// - disable bit 0 keeps port control of the pin, 1 removes it
// - converter disabled in reset and while channel select is all ones
// - after completion and before the next start the converter idles in low power
// - raw result is 12 bits in 12- and 10-bit modes, 9 bits in 8-bit mode
// - 10-bit mode rounds raw result to 10 bits across high and low result
// - 8-bit mode rounds raw result to 8 bits, written to low result only
// - storing a result sets complete flag; interrupt only when its enable is 1
// - compare against compare registers only while compare enable is set, any mode
// - four clock sources by input clock select; bus clock after reset
// - select codes 00 bus, 01 bus halved, 10 alternate, 11 internal async
// - halved bus clock plus divider gives total division up to 16
// - internal async clock made inside, keeps running in wait and stop3
// - selected source divided by 1, 2, 4 or 8 to form converter clock
// - divide codes 00 by 1, 01 by 2, 10 by 4, 11 by 8
// - mode codes 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved
// - disabled pin has its output buffer forced off
// - disabled pin has input buffer off and port read returns zero
// - disabled pin has its pull-up switched off regardless of port setting
package conv_ctrl_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 24;
  localparam int CODE_W = 12;

  localparam logic [3:0] OFF_STATUS_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS_AUX  = 4'h1;
  localparam logic [3:0] OFF_RESULT_HIGH = 4'h2;
  localparam logic [3:0] OFF_RESULT_LOW  = 4'h3;
  localparam logic [3:0] OFF_CMP_HIGH    = 4'h4;
  localparam logic [3:0] OFF_CMP_LOW     = 4'h5;
  localparam logic [3:0] OFF_CONFIG      = 4'h6;
  localparam logic [3:0] OFF_PIN_DIS_LOW = 4'h7;
  localparam logic [3:0] OFF_PIN_DIS_MID = 4'h8;
  localparam logic [3:0] OFF_PIN_DIS_HIGH = 4'h9;

  // status_ctrl: [7] complete flag (ro), [6] irq enable, [4:0] channel select
  localparam int POS_FLAG   = 7;
  localparam int POS_IRQ_EN = 6;
  localparam int CHSEL_W    = 5;
  // status_aux: [7] active (ro), [5] compare enable
  localparam int POS_ACTIVE = 7;
  localparam int POS_CMP_EN = 5;

  localparam logic [4:0] CHSEL_RESET  = 5'h1f;
  localparam logic [7:0] PIN_DIS_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  localparam logic [1:0] CLK_BUS      = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT      = 2'h2;
  localparam logic [1:0] CLK_ASYNC    = 2'h3;

  localparam logic [1:0] MODE_8  = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;

  localparam int LSB_12 = 0;
  localparam int LSB_8  = 3;

  typedef struct packed {
    logic       low_power;
    logic [1:0] divide_sel;
    logic       long_sample;
    logic [1:0] mode;
    logic [1:0] clk_sel;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{low_power: 1'b0, divide_sel: 2'h0, long_sample: 1'b0,
                                 mode: MODE_8, clk_sel: CLK_BUS};

  typedef enum logic [1:0] {ST_DISABLED, ST_IDLE, ST_CONVERT} conv_state_t;

endpackage

// *** conv_ctrl.sv ***
// converter control: registers, clock select and divide, sar sequencing, rounding, compare, pin disable
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module conv_ctrl
  import conv_ctrl_pkg::*;
#(
  parameter int ASYNC_DIV = 4
)(
  input  wire logic                I_SYS_CLK,
  input  wire logic                I_RESET,
  input  wire logic [ADDR_W-1:0]   I_ADDR,
  input  wire logic [DATA_W-1:0]   I_WDATA,
  input  wire logic                I_WR,
  input  wire logic                I_RD,
  output      logic [DATA_W-1:0]   O_RDATA,
  input  wire logic                I_ALT_CLK,
  input  wire logic                I_WAIT_STOP,
  input  wire logic                I_CMP_ABOVE,
  output      logic [CODE_W-1:0]   O_DAC_CODE,
  output      logic                O_CONV_ACTIVE,
  output      logic                O_ASYNC_CLK_RUN,
  output      logic                O_CONVERTER_CLOCK_TICK,
  output      logic                O_IRQ,
  input  wire logic [NUM_CH-1:0]   I_PORT_OUT,
  input  wire logic [NUM_CH-1:0]   I_PORT_OE,
  input  wire logic [NUM_CH-1:0]   I_PORT_PULLUP,
  input  wire logic [NUM_CH-1:0]   I_PIN_IN,
  output      logic [NUM_CH-1:0]   O_PIN_OUT,
  output      logic [NUM_CH-1:0]   O_PIN_OE,
  output      logic [NUM_CH-1:0]   O_PIN_PULLUP,
  output      logic [NUM_CH-1:0]   O_PIN_IN_EN,
  output      logic [NUM_CH-1:0]   O_PORT_READ
);

  localparam logic [7:0] ASYNC_LAST = 8'(ASYNC_DIV - 1);

  // register state
  logic [CHSEL_W-1:0] chsel_r;
  logic               irq_en_r;
  logic               flag_r;
  logic               cmp_en_r;
  cfg_t               cfg_r;
  logic [7:0]         cmp_high_r;
  logic [7:0]         cmp_low_r;
  logic [7:0]         res_high_r;
  logic [7:0]         res_low_r;
  logic [7:0]         pin_dis_low_r;
  logic [7:0]         pin_dis_mid_r;
  logic [7:0]         pin_dis_high_r;
  logic [DATA_W-1:0]  rdata_r;

  // write decode
  wire wr_ctrl   = I_WR && (I_ADDR == OFF_STATUS_CTRL);
  wire wr_aux    = I_WR && (I_ADDR == OFF_STATUS_AUX);
  wire wr_cmp_hi = I_WR && (I_ADDR == OFF_CMP_HIGH);
  wire wr_cmp_lo = I_WR && (I_ADDR == OFF_CMP_LOW);
  wire wr_cfg    = I_WR && (I_ADDR == OFF_CONFIG);
  wire wr_pd_lo  = I_WR && (I_ADDR == OFF_PIN_DIS_LOW);
  wire wr_pd_mid = I_WR && (I_ADDR == OFF_PIN_DIS_MID);
  wire wr_pd_hi  = I_WR && (I_ADDR == OFF_PIN_DIS_HIGH);
  wire rd_res_lo = I_RD && (I_ADDR == OFF_RESULT_LOW);

  // any write that changes the operating setup invalidates a running conversion
  wire abort_wr  = wr_ctrl || wr_aux || wr_cmp_hi || wr_cmp_lo || wr_cfg;
  wire chsel_off = wr_ctrl ? (&I_WDATA[CHSEL_W-1:0]) : (&chsel_r);
  wire start_req = wr_ctrl && !(&I_WDATA[CHSEL_W-1:0]);

  // read mux
  logic [DATA_W-1:0] rd_mux;
  conv_state_t       state_r;
  wire active = (state_r == ST_CONVERT);
  always_comb
  begin
    rd_mux = 8'h00;
    if (I_ADDR == OFF_STATUS_CTRL)
      rd_mux = {flag_r, irq_en_r, 1'b0, chsel_r};
    else if (I_ADDR == OFF_STATUS_AUX)
      rd_mux = {active, 1'b0, cmp_en_r, 5'h00};
    else if (I_ADDR == OFF_RESULT_HIGH)
      rd_mux = res_high_r;
    else if (I_ADDR == OFF_RESULT_LOW)
      rd_mux = res_low_r;
    else if (I_ADDR == OFF_CMP_HIGH)
      rd_mux = cmp_high_r;
    else if (I_ADDR == OFF_CMP_LOW)
      rd_mux = cmp_low_r;
    else if (I_ADDR == OFF_CONFIG)
      rd_mux = cfg_r;
    else if (I_ADDR == OFF_PIN_DIS_LOW)
      rd_mux = pin_dis_low_r;
    else if (I_ADDR == OFF_PIN_DIS_MID)
      rd_mux = pin_dis_mid_r;
    else if (I_ADDR == OFF_PIN_DIS_HIGH)
      rd_mux = pin_dis_high_r;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
      rdata_r <= 8'h00;
    else
      rdata_r <= I_RD ? rd_mux : 8'h00;
  end
  assign O_RDATA = rdata_r;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      chsel_r        <= CHSEL_RESET;
      irq_en_r       <= 1'b0;
      cmp_en_r       <= 1'b0;
      cfg_r          <= CFG_RESET;
      cmp_high_r     <= 8'h00;
      cmp_low_r      <= 8'h00;
      pin_dis_low_r  <= PIN_DIS_RESET;
      pin_dis_mid_r  <= PIN_DIS_RESET;
      pin_dis_high_r <= PIN_DIS_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        chsel_r  <= I_WDATA[CHSEL_W-1:0];
        irq_en_r <= I_WDATA[POS_IRQ_EN];
      end
      if (wr_aux)
        cmp_en_r <= I_WDATA[POS_CMP_EN];
      if (wr_cfg)
        cfg_r <= I_WDATA;
      if (wr_cmp_hi)
        cmp_high_r <= I_WDATA;
      if (wr_cmp_lo)
        cmp_low_r <= I_WDATA;
      if (wr_pd_lo)
        pin_dis_low_r <= I_WDATA;
      if (wr_pd_mid)
        pin_dis_mid_r <= I_WDATA;
      if (wr_pd_hi)
        pin_dis_high_r <= I_WDATA;
    end
  end

  // alternate clock pin: three-stage sync, edge counts once stages two and three agree
  logic [2:0] alt_sync_r;
  logic       alt_level_r;
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      alt_sync_r  <= 3'h0;
      alt_level_r <= 1'b0;
    end
    else
    begin
      alt_sync_r <= {alt_sync_r[1:0], I_ALT_CLK};
      if (alt_sync_r[1] == alt_sync_r[2])
        alt_level_r <= alt_sync_r[2];
    end
  end
  wire alt_rise = (alt_sync_r[1] == alt_sync_r[2]) && alt_sync_r[2] && !alt_level_r;

  // internal async source: runs while selected and a conversion is active, not gated by wait or stop3
  logic [7:0] async_cnt_r;
  logic       half_r;
  wire        async_run = (cfg_r.clk_sel == CLK_ASYNC) && active;
  wire        async_tick = async_run && (async_cnt_r == ASYNC_LAST);
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET || !async_run || async_tick)
      async_cnt_r <= 8'h00;
    else
      async_cnt_r <= async_cnt_r + 8'h01;
  end
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
      half_r <= 1'b0;
    else
      half_r <= !half_r;
  end
  assign O_ASYNC_CLK_RUN = async_run;

  // bus-derived sources stop in wait or stop3; the async source does not
  logic src_tick;
  always_comb
  begin
    case (cfg_r.clk_sel)
      CLK_BUS:      src_tick = !I_WAIT_STOP;
      CLK_BUS_HALF: src_tick = !I_WAIT_STOP && half_r;
      CLK_ALT:      src_tick = !I_WAIT_STOP && alt_rise;
      default:      src_tick = async_tick;
    endcase
  end

  // divider by 1, 2, 4 or 8
  logic [2:0] div_cnt_r;
  wire  [2:0] div_last = 3'((4'h1 << cfg_r.divide_sel) - 4'h1);
  wire        converter_clock_tick = src_tick && (div_cnt_r == div_last);
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET || !active || abort_wr)
      div_cnt_r <= 3'h0;
    else if (converter_clock_tick)
      div_cnt_r <= 3'h0;
    else if (src_tick)
      div_cnt_r <= div_cnt_r + 3'h1;
  end
  assign O_CONVERTER_CLOCK_TICK = converter_clock_tick && active;

  // successive approximation over the top bits of the trial code
  logic [CODE_W-1:0] code_r;
  logic [3:0]        bit_r;
  wire  [3:0]        last_bit = (cfg_r.mode == MODE_8) ? 4'(LSB_8) : 4'(LSB_12);
  wire  [CODE_W-1:0] bit_mask = 12'h001 << bit_r;
  wire  [CODE_W-1:0] code_kept = I_CMP_ABOVE ? code_r : (code_r & ~bit_mask);
  wire               sar_done = active && converter_clock_tick && (bit_r == last_bit) && !abort_wr;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
      state_r <= ST_DISABLED;
    else if (chsel_off)
      state_r <= ST_DISABLED;
    else if (start_req)
      state_r <= ST_CONVERT;
    else if (sar_done || abort_wr)
      state_r <= ST_IDLE;
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET || start_req)
    begin
      code_r <= 12'h800;
      bit_r  <= 4'hb;
    end
    else if (active && converter_clock_tick && !abort_wr)
    begin
      code_r <= (bit_r == last_bit) ? code_kept : (code_kept | (bit_mask >> 1));
      bit_r  <= (bit_r == last_bit) ? bit_r : bit_r - 4'h1;
    end
  end
  assign O_CONV_ACTIVE = active;
  assign O_DAC_CODE    = code_r;

  // rounding per mode
  wire [11:0] raw12  = code_kept;
  wire [8:0]  raw9   = code_kept[11:3];
  wire [9:0]  r10    = (&raw12[11:1]) ? 10'h3ff : raw12[11:2] + 10'(raw12[1]);
  wire [7:0]  r8     = (&raw9[8:1]) ? 8'hff : raw9[8:1] + 8'(raw9[0]);
  wire [11:0] result = (cfg_r.mode == MODE_8) ? {4'h0, r8} :
                       (cfg_r.mode == MODE_10) ? {2'h0, r10} : raw12;
  wire [11:0] cmp_val = (cfg_r.mode == MODE_8) ? {4'h0, cmp_low_r} :
                        (cfg_r.mode == MODE_10) ? {2'h0, cmp_high_r[1:0], cmp_low_r} :
                        {cmp_high_r[3:0], cmp_low_r};
  // compare holds when the result reaches the compare value; stored as the difference
  wire        cmp_hit = (result >= cmp_val);
  wire        store   = sar_done && (!cmp_en_r || cmp_hit);
  wire [11:0] stored  = cmp_en_r ? result - cmp_val : result;

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      res_high_r <= RESULT_RESET;
      res_low_r  <= RESULT_RESET;
    end
    else if (store)
    begin
      res_low_r <= stored[7:0];
      if (cfg_r.mode != MODE_8)
        res_high_r <= {4'h0, stored[11:8]};
    end
  end

  // set wins over a clear by write or result read in the same cycle
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
      flag_r <= 1'b0;
    else if (store)
      flag_r <= 1'b1;
    else if (wr_ctrl || rd_res_lo)
      flag_r <= 1'b0;
  end
  assign O_IRQ = flag_r && irq_en_r;

  // pin gating per channel
  wire [NUM_CH-1:0] pin_dis = {pin_dis_high_r, pin_dis_mid_r, pin_dis_low_r};
  logic [NUM_CH-1:0] pin_sync1_r;
  logic [NUM_CH-1:0] pin_sync2_r;
  logic [NUM_CH-1:0] pin_sync3_r;
  logic [NUM_CH-1:0] pin_level_r;
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_pin
      always_ff @(posedge I_SYS_CLK)
      begin
        if (I_RESET)
        begin
          pin_sync1_r[ch]  <= 1'b0;
          pin_sync2_r[ch]  <= 1'b0;
          pin_sync3_r[ch]  <= 1'b0;
          pin_level_r[ch]  <= 1'b0;
          O_PIN_OUT[ch]    <= 1'b0;
          O_PIN_OE[ch]     <= 1'b0;
          O_PIN_PULLUP[ch] <= 1'b0;
          O_PIN_IN_EN[ch]  <= 1'b0;
          O_PORT_READ[ch]  <= 1'b0;
        end
        else
        begin
          pin_sync1_r[ch]  <= I_PIN_IN[ch];
          pin_sync2_r[ch]  <= pin_sync1_r[ch];
          pin_sync3_r[ch]  <= pin_sync2_r[ch];
          if (pin_sync2_r[ch] == pin_sync3_r[ch])
            pin_level_r[ch] <= pin_sync3_r[ch];
          O_PIN_OUT[ch]    <= I_PORT_OUT[ch] && !pin_dis[ch];
          O_PIN_OE[ch]     <= I_PORT_OE[ch] && !pin_dis[ch];
          O_PIN_PULLUP[ch] <= I_PORT_PULLUP[ch] && !pin_dis[ch];
          O_PIN_IN_EN[ch]  <= !pin_dis[ch];
          O_PORT_READ[ch]  <= pin_level_r[ch] && !pin_dis[ch];
        end
      end
    end
  endgenerate

  // checks
  sequence s_div_gap;
    O_CONVERTER_CLOCK_TICK ##1 (!O_CONVERTER_CLOCK_TICK && active && cfg_r.clk_sel == CLK_BUS && !I_WAIT_STOP &&
                     cfg_r.divide_sel == 2'h2 && !abort_wr) [*3];
  endsequence

  a_pin_oe_off: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    pin_dis[0] && $stable(pin_dis[0]) |=> !O_PIN_OE[0])
    else $error("disabled pin still drives its output");
  a_pullup_off: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (pin_dis[23] && I_PORT_PULLUP[23]) |=> !O_PIN_PULLUP[23])
    else $error("disabled pin keeps its pull-up");
  a_read_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    pin_dis[8] |=> (!O_PORT_READ[8] && !O_PIN_IN_EN[8]))
    else $error("disabled pin reads nonzero");
  a_off_disabled: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (&chsel_r) && !start_req |=> state_r == ST_DISABLED)
    else $error("converter not disabled with all-ones channel select");
  a_store_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    store |=> flag_r ##0 (O_IRQ == irq_en_r))
    else $error("complete flag or interrupt wrong after store");
  a_round_ten: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    store && !cmp_en_r && cfg_r.mode == MODE_10 |=>
      {res_high_r[1:0], res_low_r} == $past(r10) && res_high_r[7:2] == 6'h00)
    else $error("10-bit result not rounded into result registers");
  a_cmp_block: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    sar_done && cmp_en_r && !cmp_hit |=> $stable(res_low_r) && $stable(res_high_r))
    else $error("result stored though compare failed");
  a_div_four: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    s_div_gap |=> O_CONVERTER_CLOCK_TICK)
    else $error("divide by four tick spacing wrong");
  a_reset_clean: assert property (@(posedge I_SYS_CLK)
    $fell(I_RESET) |-> pin_dis == 24'h000000 && cfg_r.clk_sel == CLK_BUS)
    else $error("pin disable or clock select not cleared by reset");
  a_idle_quiet: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    sar_done && !start_req && !chsel_off |=> !O_CONV_ACTIVE && !O_CONVERTER_CLOCK_TICK)
    else $error("converter still active after completion");
endmodule

// *** pin_cmp_model.sv ***
// far-side model: analog comparator against the trial code, and channel pins with pull-ups
`timescale 1ns/1ps
module pin_cmp_model
  import conv_ctrl_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic [CODE_W-1:0]   i_vin,
  input  wire logic [CODE_W-1:0]   i_dac_code,
  input  wire logic [NUM_CH-1:0]   i_pin_out,
  input  wire logic [NUM_CH-1:0]   i_pin_oe,
  input  wire logic [NUM_CH-1:0]   i_pin_pullup,
  output      logic                o_cmp_above,
  output      logic [NUM_CH-1:0]   o_pin_level
);
  logic [NUM_CH-1:0] float_r = '0;

  // a pin nobody drives and nobody pulls wanders, so a stale value cannot pass for a read
  always_ff @(posedge i_clk)
  begin
    float_r <= ~float_r;
  end

  assign o_cmp_above = (i_vin >= i_dac_code);
  assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_pin_pullup) | (~i_pin_oe & ~i_pin_pullup & float_r);
endmodule

// *** tb_top.sv ***
// self-checking bench for the converter pin, clock and result control block
`timescale 1ns/1ps
module tb_top;
  import conv_ctrl_pkg::*;
  localparam int ASYNC_N = 3;
  localparam int LIMIT   = 20000;
  localparam logic [NUM_CH-1:0] DIS = 24'h800181;
  logic              sys_clk, reset, wr, rd, alt_clk, wait_stop, cmp_above, acc;
  logic              conv_active, async_run, converter_clock_tick, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [CODE_W-1:0] dac_code, vin;
  logic [NUM_CH-1:0] port_out, port_oe, port_pullup, pin_level;
  logic [NUM_CH-1:0] pin_out, pin_oe, pin_pullup, pin_in_en, port_read;
  int                mismatches, compares, cycles;

  conv_ctrl #(.ASYNC_DIV(ASYNC_N)) uut (
    .I_SYS_CLK(sys_clk), .I_RESET(reset), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_ALT_CLK(alt_clk), .I_WAIT_STOP(wait_stop), .I_CMP_ABOVE(cmp_above),
    .O_DAC_CODE(dac_code), .O_CONV_ACTIVE(conv_active), .O_ASYNC_CLK_RUN(async_run),
    .O_CONVERTER_CLOCK_TICK(converter_clock_tick), .O_IRQ(irq), .I_PORT_OUT(port_out), .I_PORT_OE(port_oe),
    .I_PORT_PULLUP(port_pullup), .I_PIN_IN(pin_level), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe),
    .O_PIN_PULLUP(pin_pullup), .O_PIN_IN_EN(pin_in_en), .O_PORT_READ(port_read));

  pin_cmp_model partner (
    .i_clk(sys_clk), .i_vin(vin), .i_dac_code(dac_code), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .i_pin_pullup(pin_pullup), .o_cmp_above(cmp_above), .o_pin_level(pin_level));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // alternate clock of 7 system cycles, phase kept away from the system edges
  initial
  begin
    alt_clk = 1'b0;
    #3.3;
    forever #17.5 alt_clk = ~alt_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_idle();
    #1;
    repeat (2000)
    begin
      if (conv_active !== 1'b1)
        break;
      @(posedge sys_clk);
      #1;
    end
    chk("conv_active", 1'b0, conv_active);
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic conv(input logic [1:0] mode, input logic [CODE_W-1:0] v, input logic ien,
                      input logic [7:0] hi, input logic [7:0] lo, input logic flag);
    wr_reg(OFF_CONFIG, {4'h0, mode, CLK_BUS});
    vin <= v;
    wr_reg(OFF_STATUS_CTRL, {1'b0, ien, 6'h00});
    wait_idle();
    chk("irq", ien & flag, irq);
    chk("dac_final", (mode == MODE_8) ? {v[11:3], 3'h0} : v, dac_code);
    rd_reg(OFF_STATUS_CTRL, d);
    chk("complete_flag", flag, d[POS_FLAG]);
    rd_reg(OFF_STATUS_AUX, d);
    chk("active_bit", 1'b0, d[POS_ACTIVE]);
    chk("async_run_idle", 1'b0, async_run);
    rd_reg(OFF_RESULT_HIGH, d);
    chk("result_high", hi, d);
    rd_reg(OFF_RESULT_LOW, d);
    chk("result_low", lo, d);
    @(posedge sys_clk);
    #1 chk("irq_cleared", 1'b0, irq);
  endtask

  task automatic measure(input logic [1:0] sel, input logic [1:0] div, input logic ws, input int exp);
    int k;
    int first;
    int gap;
    logic ar;
    first = -1;
    gap   = 0;
    ar    = 1'b0;
    wr_reg(OFF_CONFIG, {1'b0, div, 1'b0, MODE_12, sel});
    wait_stop <= ws;
    wr_reg(OFF_STATUS_CTRL, 8'h00);
    for (k = 0; k < 100; k++)
    begin
      @(posedge sys_clk);
      #1;
      if (converter_clock_tick === 1'b1 && first < 0)
      begin
        first = k;
        ar    = async_run;
      end
      else if (converter_clock_tick === 1'b1 && gap == 0)
        gap = k - first;
    end
    chk("tick_gap", exp, gap);
    chk("async_run", exp != 0 && sel == CLK_ASYNC, ar);
    wr_reg(OFF_STATUS_AUX, 8'h00);
    wait_stop <= 1'b0;
    wait_idle();
  endtask

  task automatic reset_values();
    rd_reg(OFF_PIN_DIS_LOW, d);
    chk("pin_dis_low_reset", PIN_DIS_RESET, d);
    rd_reg(OFF_PIN_DIS_MID, d);
    chk("pin_dis_mid_reset", PIN_DIS_RESET, d);
    rd_reg(OFF_PIN_DIS_HIGH, d);
    chk("pin_dis_high_reset", PIN_DIS_RESET, d);
    rd_reg(OFF_CONFIG, d);
    chk("config_reset", CFG_RESET, d);
    rd_reg(OFF_STATUS_CTRL, d);
    chk("ctrl_reset", {3'h0, CHSEL_RESET}, d);
    rd_reg(4'hf, d);
    chk("unmapped", 8'h00, d);
  endtask

  // channel select all ones must not start anything
  task automatic chsel_disable();
    wr_reg(OFF_STATUS_CTRL, 8'h5f);
    acc = 1'b0;
    repeat (20)
    begin
      @(posedge sys_clk);
      #1 acc = acc | conv_active;
    end
    chk("active_chsel_off", 1'b0, acc);
  endtask

  task automatic pin_gating();
    wr_reg(OFF_PIN_DIS_LOW, 8'h81);
    wr_reg(OFF_PIN_DIS_MID, 8'h01);
    wr_reg(OFF_PIN_DIS_HIGH, 8'h80);
    repeat (8) @(posedge sys_clk);
    #1;
    chk("pin_out", port_out & ~DIS, pin_out);
    chk("pin_oe", port_oe & ~DIS, pin_oe);
    chk("pin_in_en", ~DIS, pin_in_en);
    chk("port_read", (~port_oe | port_out) & ~DIS, port_read);
    chk("pin_pullup", ~DIS, pin_pullup);
    rd_reg(OFF_PIN_DIS_HIGH, d);
    chk("pin_dis_high", 8'h80, d);
  endtask

  task automatic compare_cases();
    wr_reg(OFF_STATUS_AUX, 8'h20);
    wr_reg(OFF_CMP_HIGH, 8'h05);
    wr_reg(OFF_CMP_LOW, 8'h00);
    conv(MODE_12, 12'h5a3, 1'b1, 8'h00, 8'ha3, 1'b1);
    wr_reg(OFF_CMP_HIGH, 8'h06);
    conv(MODE_12, 12'h5a3, 1'b1, 8'h00, 8'ha3, 1'b0);
    wr_reg(OFF_STATUS_AUX, 8'h00);
  endtask

  initial
  begin
    reset       = 1'b1;
    wr          = 1'b0;
    rd          = 1'b0;
    addr        = '0;
    wdata       = '0;
    wait_stop   = 1'b0;
    vin         = '0;
    port_out    = 24'hc3c3c3;
    port_oe     = 24'h5a5a5a;
    port_pullup = 24'hffffff;
    mismatches  = 0;
    compares    = 0;
    cycles      = 0;
    repeat (15) @(posedge sys_clk);
    #1;
    chk("pin_out_reset", 24'h0, pin_out);
    chk("irq_reset", 1'b0, irq);
    chk("dac_reset", 12'h800, dac_code);
    chk("active_reset", 1'b0, conv_active);
    @(posedge sys_clk);
    reset <= 1'b0;
    reset_values();
    chsel_disable();
    pin_gating();
    conv(MODE_12, 12'h5a3, 1'b1, 8'h05, 8'ha3, 1'b1);
    conv(MODE_10, 12'h5a6, 1'b1, 8'h01, 8'h6a, 1'b1);
    conv(MODE_8, 12'h5ac, 1'b0, 8'h01, 8'h5b, 1'b1);
    compare_cases();
    // divide settings keep the converter clock in range for each source
    measure(CLK_BUS, 2'h0, 1'b0, 1);
    measure(CLK_BUS, 2'h2, 1'b0, 4);
    measure(CLK_BUS_HALF, 2'h3, 1'b0, 16);
    measure(CLK_ALT, 2'h0, 1'b0, 7);
    measure(CLK_ASYNC, 2'h1, 1'b0, 2 * ASYNC_N);
    measure(CLK_ASYNC, 2'h0, 1'b1, ASYNC_N);
    measure(CLK_BUS, 2'h0, 1'b1, 0);
    end_of_test();
  end
endmodule
